// *** mrc_reset_ctrl.sv ***
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mrc_reset_ctrl #(
   parameter int ONE_SHORT_CYC = mrc_pkg::ONE_SHORT_CYCLES,
   parameter int WDT_TIMEOUT_CYC = mrc_pkg::WATCHDOG_CYCLES
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Pins and supply monitor
   input wire logic EXT_RESET_N_PIN,
   input wire logic POWER_GOOD,
   // Static options
   input wire logic RESET_MODE_ONE_SHORT,
   input wire logic INITIAL_MODE_OPTION,
   // CPU core events
   input wire logic WATCHDOG_CLEAR_INSTR,
   input wire logic SLEEP_ENTER,
   input wire logic WAKE_EVENT,
   // Reset and clock control outputs
   output logic CHIP_RESET,
   output logic CPU_HALT,
   output logic SPEED_SELECT,
   output logic SLOW_OSC_EN,
   output logic [15:0] PROGRAM_COUNTER,
   output logic IRQ
);
   // ==========================================================
   // Pin and supply synchronisers
   // A change is accepted only once stages two and three agree, so a
   // single-cycle glitch on the pin never starts a reset.
   logic [1:0] async_in;
   logic [1:0] filt_reg;
   assign async_in = {POWER_GOOD, EXT_RESET_N_PIN};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         logic s1_reg, s2_reg, s3_reg;
         always_ff @(posedge MCLK) begin
            if (RST) begin
               s1_reg <= (gi == 0);
               s2_reg <= (gi == 0);
               s3_reg <= (gi == 0);
               filt_reg[gi] <= (gi == 0);
            end else begin
               s1_reg <= async_in[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  filt_reg[gi] <= s3_reg;
               end
            end
         end
      end
   endgenerate

   wire pin_low = !filt_reg[0];
   wire por_low = !filt_reg[1];

   // ==========================================================
   // Reset pin sequencing
   mrc_pkg::mrc_pin_state_type pin_state_reg, pin_state_next;
   logic [mrc_pkg::HOLD_CNT_W-1:0] hold_cnt_reg;
   wire hold_done = hold_cnt_reg == mrc_pkg::HOLD_CNT_W'(ONE_SHORT_CYC - 1);
   logic pin_fire;

   always_comb begin
      pin_state_next = pin_state_reg;
      pin_fire = 1'b0;
      unique case (pin_state_reg)
         mrc_pkg::PIN_IDLE: begin
            if (pin_low) begin
               pin_state_next = mrc_pkg::PIN_HELD;
            end
         end
         mrc_pkg::PIN_HELD: begin
            if (!RESET_MODE_ONE_SHORT && !pin_low) begin
               pin_fire = 1'b1;
               pin_state_next = mrc_pkg::PIN_IDLE;
            end else if (RESET_MODE_ONE_SHORT && !pin_low) begin
               pin_state_next = mrc_pkg::PIN_IDLE;
            end else if (RESET_MODE_ONE_SHORT && hold_done) begin
               pin_fire = 1'b1;
               pin_state_next = mrc_pkg::PIN_FIRED;
            end
         end
         mrc_pkg::PIN_FIRED: begin
            if (!pin_low) begin
               pin_state_next = mrc_pkg::PIN_IDLE;
            end
         end
      endcase
      if (por_low) begin
         pin_state_next = mrc_pkg::PIN_IDLE;
         pin_fire = 1'b0;
      end
   end

   wire [mrc_pkg::HOLD_CNT_W-1:0] hold_cnt_next =
      (pin_state_reg == mrc_pkg::PIN_HELD && pin_low) ? hold_cnt_reg + 1'b1 : '0;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         pin_state_reg <= mrc_pkg::PIN_IDLE;
         hold_cnt_reg <= '0;
      end else begin
         pin_state_reg <= pin_state_next;
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   // ==========================================================
   // Watchdog
   logic wd_en_reg;
   logic [mrc_pkg::WDT_CNT_W-1:0] wd_cnt_reg;
   wire wdt_expire = wd_en_reg && !por_low &&
      wd_cnt_reg == mrc_pkg::WDT_CNT_W'(WDT_TIMEOUT_CYC - 1);
   wire fire_any = pin_fire || wdt_expire;
   wire chip_rst_evt = por_low || fire_any;
   wire [mrc_pkg::WDT_CNT_W-1:0] wd_cnt_next =
      (chip_rst_evt || WATCHDOG_CLEAR_INSTR || !wd_en_reg) ? '0 : wd_cnt_reg + 1'b1;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         wd_cnt_reg <= '0;
      end else begin
         wd_cnt_reg <= wd_cnt_next;
      end
   end

   // ==========================================================
   // Reset-cause flags (active low)
   logic to_n_reg, pd_n_reg;
   wire flag_pwr_pin = por_low || pin_low;
   wire to_n_next = flag_pwr_pin ? 1'b1 :
                    wdt_expire ? 1'b0 :
                    (SLEEP_ENTER || WATCHDOG_CLEAR_INSTR) ? 1'b1 : to_n_reg;
   wire pd_n_next = flag_pwr_pin ? 1'b1 :
                    wdt_expire ? pd_n_reg :
                    SLEEP_ENTER ? 1'b0 :
                    WATCHDOG_CLEAR_INSTR ? 1'b1 : pd_n_reg;

   // Flags only follow their own events, never the general reload
   always_ff @(posedge MCLK) begin
      if (RST) begin
         to_n_reg <= 1'b1;
         pd_n_reg <= 1'b1;
      end else begin
         to_n_reg <= to_n_next;
         pd_n_reg <= pd_n_next;
      end
   end

   // ==========================================================
   // APB decode
   wire apb_acc = PSEL && PENABLE && PREADY;
   wire apb_wr = apb_acc && PWRITE;
   wire apb_rd = apb_acc && !PWRITE;
   wire [7:0] idx = PADDR[9:2];
   wire in_range = PADDR[11:10] == 2'b00 && PADDR[1:0] == 2'b00;
   wire sel_fsr = in_range && idx == mrc_pkg::IDX_INDIRECT_POINTER_B;
   wire sel_pcl = in_range && idx == mrc_pkg::IDX_PROGRAM_COUNTER_LOW;
   wire sel_pcm = in_range && idx == mrc_pkg::IDX_PROGRAM_COUNTER_MID;
   wire sel_stat = in_range && idx == mrc_pkg::IDX_RESET_CAUSE;
   wire sel_ram = in_range && idx == mrc_pkg::IDX_GENERAL_RAM;
   wire sel_dca = in_range && idx == mrc_pkg::IDX_PORT_A_DIRECTION;
   wire sel_dcb = in_range && idx == mrc_pkg::IDX_PORT_B_DIRECTION;
   wire sel_dcc = in_range && idx == mrc_pkg::IDX_PORT_C_DIRECTION;
   wire sel_cpu = in_range && idx == mrc_pkg::IDX_CPU_MODE_CONTROL;
   wire sel_wdc = in_range && idx == mrc_pkg::IDX_WATCHDOG_CTRL;
   wire sel_ist = in_range && idx == mrc_pkg::IDX_IRQ_STATUS;
   wire sel_imk = in_range && idx == mrc_pkg::IDX_IRQ_MASK;
   wire sel_any = sel_fsr || sel_pcl || sel_pcm || sel_stat || sel_ram || sel_dca ||
      sel_dcb || sel_dcc || sel_cpu || sel_wdc || sel_ist || sel_imk;

   // ==========================================================
   // Special function registers
   logic [7:0] fsr_reg, pcl_reg, pcm_reg, ram_reg, dcb_reg, dcc_reg;
   logic [5:0] dca_reg;
   logic [2:0] cpu_reg;
   logic [2:0] cpu_next;
   always_comb begin
      cpu_next = cpu_reg;
      if (chip_rst_evt) begin
         cpu_next = mrc_pkg::INIT_CPU_MODE_CONTROL;
         cpu_next[mrc_pkg::SPEED_SELECT_BIT] = INITIAL_MODE_OPTION;
      end else if (apb_wr && sel_cpu) begin
         cpu_next = PWDATA[2:0];
      end
   end

   // A chip reset wins over a write in the same cycle
   always_ff @(posedge MCLK) begin
      if (RST || chip_rst_evt) begin
         fsr_reg <= mrc_pkg::INIT_INDIRECT_POINTER_B;
         pcl_reg <= mrc_pkg::INIT_ZERO;
         pcm_reg <= mrc_pkg::INIT_ZERO;
         dca_reg <= mrc_pkg::INIT_PORT_A_DIRECTION;
         dcb_reg <= mrc_pkg::INIT_PORT_BC_DIRECTION;
         dcc_reg <= mrc_pkg::INIT_PORT_BC_DIRECTION;
      end else if (apb_wr) begin
         if (sel_fsr) fsr_reg <= PWDATA[7:0];
         if (sel_pcl) pcl_reg <= PWDATA[7:0];
         if (sel_pcm) pcm_reg <= PWDATA[7:0];
         if (sel_dca) dca_reg <= PWDATA[5:0];
         if (sel_dcb) dcb_reg <= PWDATA[7:0];
         if (sel_dcc) dcc_reg <= PWDATA[7:0];
      end
   end

   // Mode bits; the block reset loads INIT_CPU_MODE_CONTROL alone, without the option
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cpu_reg <= mrc_pkg::INIT_CPU_MODE_CONTROL;
      end else begin
         cpu_reg <= cpu_next;
      end
   end

   // General RAM survives chip resets; only the block reset clears it
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ram_reg <= mrc_pkg::INIT_ZERO;
      end else if (apb_wr && sel_ram) begin
         ram_reg <= PWDATA[7:0];
      end
   end

   // Watchdog enable is not a reloaded register, so expiry cannot disarm it
   always_ff @(posedge MCLK) begin
      if (RST) begin
         wd_en_reg <= 1'b0;
      end else if (apb_wr && sel_wdc) begin
         wd_en_reg <= PWDATA[mrc_pkg::WATCHDOG_EN_BIT];
      end
   end

   // ==========================================================
   // Interrupts: sticky cause bits, cleared by reading them
   mrc_pkg::mrc_cause_type ist_reg, imk_reg, ist_evt;
   assign ist_evt = '{watchdog: wdt_expire, pin: pin_fire, power_on: por_low};
   // Only the bits actually returned are cleared, so an event landing
   // during the wait state is not lost
   wire [2:0] ist_keep = (apb_rd && sel_ist) ? ist_reg & ~PRDATA[2:0] : ist_reg;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ist_reg <= '0;
         imk_reg <= '0;
      end else begin
         ist_reg <= ist_keep | ist_evt;
         if (apb_wr && sel_imk) imk_reg <= PWDATA[2:0];
      end
   end

   // ==========================================================
   // Read mux; unimplemented bits read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (sel_fsr) rd_mux[7:0] = fsr_reg;
      if (sel_pcl) rd_mux[7:0] = pcl_reg;
      if (sel_pcm) rd_mux[7:0] = pcm_reg;
      if (sel_stat) rd_mux[7:6] = {to_n_reg, pd_n_reg};
      if (sel_ram) rd_mux[7:0] = ram_reg;
      if (sel_dca) rd_mux[5:0] = dca_reg;
      if (sel_dcb) rd_mux[7:0] = dcb_reg;
      if (sel_dcc) rd_mux[7:0] = dcc_reg;
      if (sel_cpu) rd_mux[2:0] = cpu_reg;
      if (sel_wdc) rd_mux[0] = wd_en_reg;
      if (sel_ist) rd_mux[2:0] = ist_reg;
      if (sel_imk) rd_mux[2:0] = imk_reg;
   end

   // One wait state keeps PREADY and PRDATA registered
   wire ready_next = PSEL && PENABLE && !PREADY;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= ready_next;
         PRDATA <= ready_next && !PWRITE ? rd_mux : 32'h0;
         PSLVERR <= ready_next && !sel_any;
      end
   end

   // ==========================================================
   // Outputs
   wire halt_next = !RESET_MODE_ONE_SHORT && pin_state_next == mrc_pkg::PIN_HELD;
   wire osc_next = chip_rst_evt ? 1'b1 :
      (SLEEP_ENTER && !cpu_reg[mrc_pkg::SLEEP_SELECT_BIT]) ? 1'b0 :
      WAKE_EVENT ? 1'b1 : SLOW_OSC_EN;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         CHIP_RESET <= 1'b1;
         CPU_HALT <= 1'b0;
         SPEED_SELECT <= 1'b0;
         SLOW_OSC_EN <= 1'b1;
         PROGRAM_COUNTER <= 16'h0;
         IRQ <= 1'b0;
      end else begin
         CHIP_RESET <= chip_rst_evt;
         CPU_HALT <= halt_next;
         SPEED_SELECT <= cpu_next[mrc_pkg::SPEED_SELECT_BIT];
         SLOW_OSC_EN <= osc_next;
         PROGRAM_COUNTER <= chip_rst_evt ? 16'h0 : {pcm_reg, pcl_reg};
         IRQ <= |((ist_keep | ist_evt) & imk_reg);
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   localparam int HOLD_CNT_W_C = mrc_pkg::HOLD_CNT_W;

   por_hold_a: assert property (por_low |=> CHIP_RESET && PROGRAM_COUNTER == 16'h0)
      else $error("supply low did not hold reset");
   source_reset_a: assert property (fire_any |=> CHIP_RESET && fsr_reg == 8'h80)
      else $error("reset source did not reset chip");
   level_halt_a: assert property (
      !RESET_MODE_ONE_SHORT && pin_state_reg == mrc_pkg::PIN_HELD && pin_low |=> CPU_HALT)
      else $error("level-hold pin did not halt");
   oneshot_time_a: assert property (
      pin_fire && RESET_MODE_ONE_SHORT |-> hold_cnt_reg == HOLD_CNT_W_C'(ONE_SHORT_CYC - 1))
      else $error("one-short reset at wrong time");
   wdt_clear_a: assert property (
      WATCHDOG_CLEAR_INSTR |=> wd_cnt_reg == '0 && !CHIP_RESET || $past(chip_rst_evt))
      else $error("watchdog clear ignored");
   pd_sleep_a: assert property (
      SLEEP_ENTER && !flag_pwr_pin && !wdt_expire |=> !pd_n_reg && to_n_reg)
      else $error("sleep did not mark power-down");
   to_wdt_a: assert property (
      wdt_expire && !flag_pwr_pin |=> !to_n_reg && pd_n_reg == $past(pd_n_reg))
      else $error("watchdog reset flags wrong");
   speed_load_a: assert property (
      chip_rst_evt |=> SPEED_SELECT == $past(INITIAL_MODE_OPTION) && SLOW_OSC_EN)
      else $error("speed select not reloaded");
   wdt_reset_clr_a: assert property (chip_rst_evt |=> wd_cnt_reg == '0)
      else $error("watchdog not cleared by reset");

   por_seen_c: cover property (por_low ##1 !por_low);
   oneshot_c: cover property (pin_fire && RESET_MODE_ONE_SHORT);
   level_c: cover property (pin_fire && !RESET_MODE_ONE_SHORT);
   wdt_c: cover property (wdt_expire);
endmodule
`default_nettype wire

// *** mrc_pkg.sv ***
package mrc_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_INDIRECT_POINTER_B = 8'h04;
   localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW = 8'h07;
   localparam logic [7:0] IDX_PROGRAM_COUNTER_MID = 8'h08;
   localparam logic [7:0] IDX_RESET_CAUSE = 8'h0f;
   localparam logic [7:0] IDX_GENERAL_RAM = 8'h13;
   localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h2d;
   localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h2f;
   localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h31;
   localparam logic [7:0] IDX_CPU_MODE_CONTROL = 8'h34;
   localparam logic [7:0] IDX_WATCHDOG_CTRL = 8'h40;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h41;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h42;
   // ==========================================================
   // Field positions
   localparam int TIMEOUT_FLAG_BIT = 7;
   localparam int POWERDOWN_FLAG_BIT = 6;
   localparam int SPEED_SELECT_BIT = 0;
   localparam int SLEEP_SELECT_BIT = 1;
   localparam int GLOBAL_INT_BIT = 2;
   localparam int WATCHDOG_EN_BIT = 0;
   // ==========================================================
   // Initial values loaded by every chip reset
   localparam logic [7:0] INIT_ZERO = 8'h00;
   localparam logic [7:0] INIT_INDIRECT_POINTER_B = 8'h80;
   localparam logic [5:0] INIT_PORT_A_DIRECTION = 6'h3f;
   localparam logic [7:0] INIT_PORT_BC_DIRECTION = 8'hff;
   localparam logic [2:0] INIT_CPU_MODE_CONTROL = 3'h0;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int ONE_SHORT_TIME_US = 7800;
   localparam int ONE_SHORT_CYCLES = (ONE_SHORT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WATCHDOG_CYCLES = 16384;
   localparam int HOLD_CNT_W = 20;
   localparam int WDT_CNT_W = 20;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {PIN_IDLE, PIN_HELD, PIN_FIRED} mrc_pin_state_type;
   typedef struct packed {
      logic watchdog;
      logic pin;
      logic power_on;
   } mrc_cause_type;
endpackage

// *** mrc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Core, reset key and supply monitor around the reset block
module mrc_core_model #(
   parameter int SERVICE_CYC = 12
) (
   // Clock and bench controls
   input wire logic clk,
   input wire logic service_en,
   input wire logic key_pressed,
   input wire logic supply_ok,
   // Core events
   output logic clear_instr,
   output logic sleep_enter,
   output logic wake_event,
   // Pin and supply
   output logic reset_pin_n,
   output logic power_good
);
   int cnt = 0;
   logic svc = 1'b0;
   logic man_clr = 1'b0;
   initial begin
      sleep_enter = 1'b0;
      wake_event = 1'b0;
   end
   // Software services the watchdog well inside its period
   always @(posedge clk) begin
      cnt <= service_en ? (cnt + 1) % SERVICE_CYC : 0;
      svc <= service_en && cnt == SERVICE_CYC - 1;
   end
   assign clear_instr = svc | man_clr;
   // Pull-up keeps the pin high whenever the key is released
   assign reset_pin_n = !key_pressed;
   assign power_good = supply_ok;
   task automatic pulse(input int which);
      @(posedge clk);
      case (which)
         0: man_clr <= 1'b1;
         1: sleep_enter <= 1'b1;
         default: wake_event <= 1'b1;
      endcase
      @(posedge clk);
      man_clr <= 1'b0;
      sleep_enter <= 1'b0;
      wake_event <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   localparam int OS_CYC = 20;
   localparam int WD_CYC = 30;
   localparam logic [11:0] A_PTR = {2'b00, mrc_pkg::IDX_INDIRECT_POINTER_B, 2'b00};
   localparam logic [11:0] A_PCL = {2'b00, mrc_pkg::IDX_PROGRAM_COUNTER_LOW, 2'b00};
   localparam logic [11:0] A_PCM = {2'b00, mrc_pkg::IDX_PROGRAM_COUNTER_MID, 2'b00};
   localparam logic [11:0] A_ST = {2'b00, mrc_pkg::IDX_RESET_CAUSE, 2'b00};
   localparam logic [11:0] A_RAM = {2'b00, mrc_pkg::IDX_GENERAL_RAM, 2'b00};
   localparam logic [11:0] A_PA = {2'b00, mrc_pkg::IDX_PORT_A_DIRECTION, 2'b00};
   localparam logic [11:0] A_PB = {2'b00, mrc_pkg::IDX_PORT_B_DIRECTION, 2'b00};
   localparam logic [11:0] A_PC = {2'b00, mrc_pkg::IDX_PORT_C_DIRECTION, 2'b00};
   localparam logic [11:0] A_CPU = {2'b00, mrc_pkg::IDX_CPU_MODE_CONTROL, 2'b00};
   localparam logic [11:0] A_WD = {2'b00, mrc_pkg::IDX_WATCHDOG_CTRL, 2'b00};
   localparam logic [11:0] A_IST = {2'b00, mrc_pkg::IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] A_IMSK = {2'b00, mrc_pkg::IDX_IRQ_MASK, 2'b00};
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, pin_n, pgood, clr_i, slp_i, wake_i;
   logic chip_rst, halt, speed, osc_en, irq, prev_rst = 1'b0;
   logic one_short = 1'b0, svc_en = 1'b0, key = 1'b0, supply = 1'b1;
   logic [15:0] pc;
   logic [2:0] irq_st = 3'h0;
   logic to_n = 1'b1, pd_n = 1'b1;
   int num_errors = 0, n_checks = 0, seed = 76, resets = 0;
   int model[int];
   int bad[2] = '{'h0fc, 'h011};
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      prev_rst <= chip_rst;
      if (chip_rst && !prev_rst && !rst) resets <= resets + 1;
   end
   mrc_reset_ctrl #(.ONE_SHORT_CYC(OS_CYC), .WDT_TIMEOUT_CYC(WD_CYC)) uut (
      .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .EXT_RESET_N_PIN(pin_n), .POWER_GOOD(pgood),
      .RESET_MODE_ONE_SHORT(one_short), .INITIAL_MODE_OPTION(1'b1),
      .WATCHDOG_CLEAR_INSTR(clr_i), .SLEEP_ENTER(slp_i), .WAKE_EVENT(wake_i),
      .CHIP_RESET(chip_rst), .CPU_HALT(halt), .SPEED_SELECT(speed),
      .SLOW_OSC_EN(osc_en), .PROGRAM_COUNTER(pc), .IRQ(irq));
   mrc_core_model core (.clk(mclk), .service_en(svc_en), .key_pressed(key),
      .supply_ok(supply), .clear_instr(clr_i), .sleep_enter(slp_i),
      .wake_event(wake_i), .reset_pin_n(pin_n), .power_good(pgood));
   // ==========================================================
   // Reference model and bus tasks
   function automatic int msk(input int a);
      if (a == A_PA) return 'h3f;
      if (a == A_CPU) return 'h07;
      return 'hff;
   endfunction
   task automatic reload();
      model[A_PTR] = 'h80;
      model[A_PCL] = 0;
      model[A_PCM] = 0;
      model[A_PA] = 'h3f;
      model[A_PB] = 'hff;
      model[A_PC] = 'hff;
      model[A_CPU] = 1;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) num_errors++;
   endtask
   task automatic wr(input int a, input int d);
      apb(1'b1, a[11:0], d);
      if (model.exists(a)) model[a] = d & msk(a);
   endtask
   task automatic rchk(input int a, input int e);
      apb(1'b0, a[11:0], 32'h0);
      `CHK(rd, 32'(e))
   endtask
   task automatic rstat();
      apb(1'b0, A_ST, 32'h0);
      `CHK(rd[7:6], {to_n, pd_n})
   endtask
   task automatic rirq();
      `CHK(irq, |irq_st)
      rchk(A_IST, irq_st);
      irq_st = 3'h0;
      repeat (2) @(posedge mclk);
      `CHK(irq, 1'b0)
   endtask
   task automatic settle();
      int n;
      n = 0;
      while (chip_rst !== 1'b0 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      `CHK(chip_rst, 1'b0)
      reload();
      @(posedge mclk);
      `CHK(pc, 16'h0)
      `CHK(speed, 1'b1)
      `CHK(osc_en, 1'b1)
   endtask
   task automatic wait_reset(input int lim);
      int s, n;
      s = resets;
      n = 0;
      while (resets == s && n < lim) begin
         @(posedge mclk);
         n++;
      end
      `CHK(resets != s, 1'b1)
      settle();
   endtask
   task automatic chk_regs();
      foreach (model[k]) rchk(k, model[k]);
   endtask
   task automatic final_report();
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      int s, n;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      settle();
      rstat();
      chk_regs();
      irq_st = 3'h1;
      `CHK(irq, 1'b0)
      wr(A_IMSK, 7);
      repeat (2) @(posedge mclk);
      rirq();
      foreach (bad[i]) begin
         apb(1'b0, bad[i][11:0], 32'h0);
         `CHK({err, rd}, 33'h100000000)
      end
      wr(A_ST, 0);
      rstat();
      model[A_RAM] = 0;
      foreach (model[k]) if (k != A_CPU) wr(k, $random(seed));
      wr(A_CPU, 'h2);
      repeat (3) @(posedge mclk);
      `CHK(speed, 1'b0)
      chk_regs();
      // Level hold: halted while held, reset only on release
      s = resets;
      key <= 1'b1;
      repeat (10) @(posedge mclk);
      `CHK(halt, 1'b1)
      repeat (40) @(posedge mclk);
      `CHK(resets, s)
      key <= 1'b0;
      wait_reset(15);
      `CHK(halt, 1'b0)
      irq_st |= 3'h2;
      rstat();
      chk_regs();
      rirq();
      // One-short: reset while still held, never early
      s = resets;
      one_short <= 1'b1;
      key <= 1'b1;
      repeat (12) @(posedge mclk);
      `CHK(resets, s)
      wait_reset(OS_CYC + 15);
      `CHK(halt, 1'b0)
      s = resets;
      repeat (40) @(posedge mclk);
      `CHK(resets, s)
      key <= 1'b0;
      repeat (10) @(posedge mclk);
      key <= 1'b1;
      repeat (8) @(posedge mclk);
      key <= 1'b0;
      repeat (40) @(posedge mclk);
      `CHK(resets, s)
      one_short <= 1'b0;
      irq_st |= 3'h2;
      rirq();
      // Watchdog: serviced, then from sleep, then awake
      s = resets;
      wr(A_WD, 1);
      svc_en <= 1'b1;
      repeat (150) @(posedge mclk);
      `CHK(resets, s)
      svc_en <= 1'b0;
      core.pulse(1);
      pd_n = 1'b0;
      rstat();
      wait_reset(60);
      wr(A_WD, 0);
      to_n = 1'b0;
      rstat();
      core.pulse(2);
      core.pulse(0);
      to_n = 1'b1;
      pd_n = 1'b1;
      rstat();
      wr(A_WD, 1);
      wait_reset(60);
      s = resets;
      n = 0;
      while (resets == s && n < 100) begin
         @(posedge mclk);
         n++;
      end
      `CHK(n > WD_CYC - 5 && n < WD_CYC + 5, 1'b1)
      settle();
      wr(A_WD, 0);
      to_n = 1'b0;
      rstat();
      irq_st |= 3'h4;
      rirq();
      // Supply drop holds reset for its whole length
      wr(A_PTR, $random(seed));
      supply <= 1'b0;
      repeat (8) @(posedge mclk);
      repeat (10) begin
         @(posedge mclk);
         `CHK(chip_rst, 1'b1)
      end
      supply <= 1'b1;
      settle();
      to_n = 1'b1;
      rstat();
      chk_regs();
      irq_st |= 3'h1;
      rirq();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      final_report();
   end
endmodule
`default_nettype wire
